/* File: design/pwmoc_pkg.sv */
package pwmoc_pkg;

    // Clock and microsecond timebase
    localparam int unsigned CLK_FREQ_HZ  = 50_000_000;
    localparam int unsigned US_PER_S     = 1_000_000;
    localparam int unsigned TICK_CYCLES  = CLK_FREQ_HZ / US_PER_S;
    localparam int unsigned TICK_W       = 6;

    // Duty value formats and their full scales
    localparam logic [1:0]  FMT_ANALOG   = 2'h0;
    localparam logic [1:0]  FMT_PCT      = 2'h1;
    localparam logic [1:0]  FMT_PERMILLE = 2'h2;
    localparam logic [1:0]  FMT_PER10K   = 2'h3;
    localparam logic [15:0] FS_ANALOG    = 16'h6C00;
    localparam logic [15:0] FS_PCT       = 16'h0064;
    localparam logic [15:0] FS_PERMILLE  = 16'h03E8;
    localparam logic [15:0] FS_PER10K    = 16'h2710;

    // Time limits and reset values, microseconds
    localparam logic [31:0] PERIOD_MIN_HS_US = 32'h0000_000A;
    localparam logic [31:0] PERIOD_MIN_US    = 32'h0000_0064;
    localparam logic [31:0] TIME_MAX_US      = 32'h0510_FF40;
    localparam logic [31:0] PERIOD_RST_US    = 32'h001E_8480;
    localparam logic [31:0] ON_DELAY_RST_US  = 32'h0000_0000;
    localparam logic [31:0] MIN_WIDTH_RST_US = 32'h0000_0000;

    // Runtime load target select codes
    localparam logic [1:0]  SEL_PERIOD   = 2'h1;
    localparam logic [1:0]  SEL_ON_DELAY = 2'h2;

    // Divider geometry
    localparam int unsigned DIV_NUM_W    = 64;
    localparam int unsigned DIV_DEN_W    = 32;
    localparam int unsigned DIV_CNT_W    = 7;

    typedef enum logic [1:0]
    {
        RUN_IDLE  = 2'b00,
        RUN_SYNC  = 2'b01,
        RUN_DELAY = 2'b10,
        RUN_PULSE = 2'b11
    } pwmoc_run_t;

    typedef enum logic [2:0]
    {
        CALC_PREP  = 3'b000,
        CALC_ISO_M = 3'b001,
        CALC_ISO_K = 3'b010,
        CALC_ISO_F = 3'b011,
        CALC_WIDTH = 3'b100
    } pwmoc_calc_t;

endpackage

/* File: design/pwmoc_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmoc_divider
    import pwmoc_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  start_i,
    input  wire logic [DIV_NUM_W-1:0]  num_i,
    input  wire logic [DIV_DEN_W-1:0]  den_i,
    output logic                       done_o,
    output logic      [DIV_NUM_W-1:0]  quot_o
);

    // Restoring divider, one quotient bit per clock; zero divisor gives all ones
    logic [DIV_NUM_W-1:0] quot_reg, quot_next;
    logic [DIV_DEN_W:0]   rem_reg, rem_next;
    logic [DIV_DEN_W-1:0] den_reg, den_next;
    logic [DIV_CNT_W-1:0] cnt_reg, cnt_next;
    logic                 busy_reg, busy_next;
    logic                 done_reg, done_next;

    always_comb
    begin
        logic [DIV_DEN_W:0] trial;
        trial     = {rem_reg[DIV_DEN_W-1:0], quot_reg[DIV_NUM_W-1]};
        quot_next = quot_reg;
        rem_next  = rem_reg;
        den_next  = den_reg;
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start_i)
        begin
            quot_next = num_i;
            rem_next  = '0;
            den_next  = den_i;
            cnt_next  = '0;
            busy_next = 1'b1;
        end
        else if (busy_reg)
        begin
            if (trial >= {1'b0, den_reg})
            begin
                rem_next  = trial - {1'b0, den_reg};
                quot_next = {quot_reg[DIV_NUM_W-2:0], 1'b1};
            end
            else
            begin
                rem_next  = trial;
                quot_next = {quot_reg[DIV_NUM_W-2:0], 1'b0};
            end
            cnt_next = cnt_reg + 7'h01;
            if (cnt_reg == 7'(DIV_NUM_W - 1))
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            quot_reg <= '0;
            rem_reg  <= '0;
            den_reg  <= '0;
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            quot_reg <= quot_next;
            rem_reg  <= rem_next;
            den_reg  <= den_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;
    assign quot_o = quot_reg;

endmodule
`default_nettype wire

/* File: design/pwmoc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmoc_channel
    import pwmoc_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic               rst_n_i,
    input  wire logic               software_run_request_i,
    input  wire logic [15:0]        duty_value_i,
    input  wire logic [1:0]         output_format_i,
    input  wire logic               high_speed_i,
    input  wire logic               cfg_load_i,
    input  wire logic [31:0]        cfg_period_us_i,
    input  wire logic [31:0]        cfg_on_delay_us_i,
    input  wire logic [31:0]        cfg_min_width_us_i,
    input  wire logic               load_strobe_i,
    input  wire logic               load_persistence_i,
    input  wire logic [1:0]         load_target_select_i,
    input  wire logic [31:0]        load_value_i,
    input  wire logic               iso_mode_i,
    input  wire logic [31:0]        app_cycle_us_i,
    input  wire logic               cycle_sync_i,
    input  wire logic               current_ctrl_i,
    input  wire logic [15:0]        current_duty_i,
    input  wire logic signed [15:0] dither_us_i,
    output logic                    pulse_output_o,
    output logic                    sequence_running_flag_o,
    output logic      [31:0]        active_period_us_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter storage and range limits

    logic [31:0] req_period_reg, req_period_next;
    logic [31:0] on_delay_reg, on_delay_next;
    logic [31:0] min_width_reg, min_width_next;
    logic [31:0] period_lim;
    logic [31:0] period_floor;

    always_comb
    begin
        req_period_next = req_period_reg;
        on_delay_next   = on_delay_reg;
        min_width_next  = min_width_reg;
        if (cfg_load_i)
        begin
            req_period_next = cfg_period_us_i;
            on_delay_next   = cfg_on_delay_us_i;
            min_width_next  = (cfg_min_width_us_i > TIME_MAX_US) ? TIME_MAX_US
                                                                   : cfg_min_width_us_i;
        end
        // Persistent loads track every cycle; one-shot loads need the strobe
        if (load_strobe_i || load_persistence_i)
        begin
            if (load_target_select_i == SEL_PERIOD)
                req_period_next = load_value_i;
            else if (load_target_select_i == SEL_ON_DELAY)
                on_delay_next = (load_value_i > TIME_MAX_US) ? TIME_MAX_US
                                                             : load_value_i;
        end
    end

    assign period_floor = high_speed_i ? PERIOD_MIN_HS_US : PERIOD_MIN_US;
    assign period_lim   = (req_period_reg < period_floor) ? period_floor :
                          (req_period_reg > TIME_MAX_US)  ? TIME_MAX_US  : req_period_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Background computation of next period and pulse width

    pwmoc_calc_t          calc_state_reg, calc_state_next;
    logic [31:0]          calc_period_reg, calc_period_next;
    logic [31:0]          next_period_reg, next_period_next;
    logic [31:0]          next_width_reg, next_width_next;
    logic                 div_start;
    logic [DIV_NUM_W-1:0] div_num;
    logic [DIV_DEN_W-1:0] div_den;
    logic                 div_done;
    logic [DIV_NUM_W-1:0] div_quot;
    logic [15:0]          duty_eff;
    logic [15:0]          full_scale;

    always_comb
    begin
        if (current_ctrl_i)
        begin
            full_scale = FS_PER10K;
            duty_eff   = current_duty_i;
        end
        else
        begin
            case (output_format_i)
                FMT_PCT:      full_scale = FS_PCT;
                FMT_PERMILLE: full_scale = FS_PERMILLE;
                FMT_PER10K:   full_scale = FS_PER10K;
                default:      full_scale = FS_ANALOG;
            endcase
            duty_eff = duty_value_i;
        end
        if (duty_eff > full_scale)
            duty_eff = full_scale;
    end

    always_comb
    begin
        logic [31:0]        p;
        logic [63:0]        prod;
        logic [31:0]        w;
        logic signed [33:0] wd;
        logic [31:0]        hi;
        p                = calc_period_reg;
        prod             = '0;
        w                = '0;
        wd               = '0;
        hi               = '0;
        calc_state_next  = calc_state_reg;
        calc_period_next = calc_period_reg;
        next_period_next = next_period_reg;
        next_width_next  = next_width_reg;
        div_start        = 1'b0;
        div_num          = '0;
        div_den          = '0;
        case (calc_state_reg)
            CALC_PREP:
            begin
                div_start = 1'b1;
                if (iso_mode_i && (app_cycle_us_i != 32'h0000_0000))
                begin
                    // Rounded quotients pick the ratio nearest the request
                    if (period_lim >= app_cycle_us_i)
                    begin
                        div_num = 64'(period_lim) + 64'(app_cycle_us_i >> 1);
                        div_den = app_cycle_us_i;
                        calc_state_next = CALC_ISO_M;
                    end
                    else
                    begin
                        div_num = 64'(app_cycle_us_i) + 64'(period_lim >> 1);
                        div_den = period_lim;
                        calc_state_next = CALC_ISO_K;
                    end
                end
                else
                begin
                    p = period_lim;
                    div_num = 64'(p) * 64'(duty_eff);
                    div_den = 32'(full_scale);
                    calc_period_next = p;
                    calc_state_next  = CALC_WIDTH;
                end
            end
            CALC_ISO_M:
                if (div_done)
                begin
                    prod = ((div_quot == 64'h0) ? 64'h1 : div_quot) * 64'(app_cycle_us_i);
                    p = (prod > 64'(TIME_MAX_US)) ? TIME_MAX_US : prod[31:0];
                    div_start = 1'b1;
                    div_num = 64'(p) * 64'(duty_eff);
                    div_den = 32'(full_scale);
                    calc_period_next = p;
                    calc_state_next  = CALC_WIDTH;
                end
            CALC_ISO_K:
                if (div_done)
                begin
                    div_start = 1'b1;
                    div_num = 64'(app_cycle_us_i);
                    div_den = (div_quot == 64'h0) ? 32'h0000_0001 : div_quot[31:0];
                    calc_state_next = CALC_ISO_F;
                end
            CALC_ISO_F:
                if (div_done)
                begin
                    // Fraction rounds down to whole microseconds
                    p = (div_quot[31:0] == 32'h0) ? 32'h0000_0001 : div_quot[31:0];
                    div_start = 1'b1;
                    div_num = 64'(p) * 64'(duty_eff);
                    div_den = 32'(full_scale);
                    calc_period_next = p;
                    calc_state_next  = CALC_WIDTH;
                end
            CALC_WIDTH:
                if (div_done)
                begin
                    w = div_quot[31:0];
                    if (!current_ctrl_i)
                    begin
                        hi = (min_width_reg > p) ? 32'h0 : p - min_width_reg;
                        if (w < min_width_reg)
                            w = '0;
                        else if (w > hi)
                            w = p;
                        else
                        begin
                            // Dither only moves widths already inside the band
                            wd = 34'(signed'({2'b00, w})) + 34'(dither_us_i);
                            if (wd < 34'(signed'({2'b00, min_width_reg})))
                                w = min_width_reg;
                            else if (wd > 34'(signed'({2'b00, hi})))
                                w = hi;
                            else
                                w = wd[31:0];
                        end
                    end
                    next_period_next = p;
                    next_width_next  = w;
                    calc_state_next  = CALC_PREP;
                end
            default:
                calc_state_next = CALC_PREP;
        endcase
    end

    pwmoc_divider u_divider
    (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .start_i (div_start),
        .num_i   (div_num),
        .den_i   (div_den),
        .done_o  (div_done),
        .quot_o  (div_quot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output sequence

    pwmoc_run_t        run_state_reg, run_state_next;
    logic              run_prev_reg;
    logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic              tick;
    logic [31:0]       delay_cnt_reg, delay_cnt_next;
    logic [31:0]       pos_reg, pos_next;
    logic [31:0]       act_period_reg, act_period_next;
    logic [31:0]       act_width_reg, act_width_next;
    logic              pulse_reg, pulse_next;
    logic              running_reg, running_next;
    logic              period_start;

    assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

    always_comb
    begin
        run_state_next  = run_state_reg;
        tick_cnt_next   = tick ? '0 : tick_cnt_reg + 6'h01;
        delay_cnt_next  = delay_cnt_reg;
        pos_next        = pos_reg;
        pulse_next      = pulse_reg;
        running_next    = running_reg;
        period_start    = 1'b0;
        case (run_state_reg)
            RUN_IDLE:
                if (software_run_request_i && !run_prev_reg)
                begin
                    running_next  = 1'b1;
                    tick_cnt_next = '0;
                    if (iso_mode_i)
                        run_state_next = RUN_SYNC;
                    else if (on_delay_reg == 32'h0)
                        period_start = 1'b1;
                    else
                    begin
                        delay_cnt_next = on_delay_reg;
                        run_state_next = RUN_DELAY;
                    end
                end
            RUN_SYNC:
                if (cycle_sync_i)
                    period_start = 1'b1;
            RUN_DELAY:
                if (tick)
                begin
                    delay_cnt_next = delay_cnt_reg - 32'h1;
                    if (delay_cnt_reg == 32'h1)
                        period_start = 1'b1;
                end
            RUN_PULSE:
            begin
                if (iso_mode_i && cycle_sync_i && (act_period_reg <= app_cycle_us_i))
                    period_start = 1'b1;
                else if (tick)
                begin
                    pos_next   = pos_reg + 32'h1;
                    pulse_next = (pos_next < act_width_reg);
                    if (pos_next >= act_period_reg)
                        period_start = 1'b1;
                end
            end
            default:
                run_state_next = RUN_IDLE;
        endcase
        act_period_next = act_period_reg;
        act_width_next  = act_width_reg;
        if (period_start)
        begin
            run_state_next  = RUN_PULSE;
            act_period_next = next_period_reg;
            act_width_next  = next_width_reg;
            pos_next        = '0;
            pulse_next      = (next_width_reg != 32'h0);
            tick_cnt_next   = '0;
        end
        if (!software_run_request_i)
        begin
            run_state_next = RUN_IDLE;
            pulse_next     = 1'b0;
            running_next   = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_period_reg  <= PERIOD_RST_US;
            on_delay_reg    <= ON_DELAY_RST_US;
            min_width_reg   <= MIN_WIDTH_RST_US;
            calc_state_reg  <= CALC_PREP;
            calc_period_reg <= PERIOD_RST_US;
            next_period_reg <= PERIOD_RST_US;
            next_width_reg  <= '0;
            run_state_reg   <= RUN_IDLE;
            run_prev_reg    <= 1'b0;
            tick_cnt_reg    <= '0;
            delay_cnt_reg   <= '0;
            pos_reg         <= '0;
            act_period_reg  <= PERIOD_RST_US;
            act_width_reg   <= '0;
            pulse_reg       <= 1'b0;
            running_reg     <= 1'b0;
        end
        else
        begin
            req_period_reg  <= req_period_next;
            on_delay_reg    <= on_delay_next;
            min_width_reg   <= min_width_next;
            calc_state_reg  <= calc_state_next;
            calc_period_reg <= calc_period_next;
            next_period_reg <= next_period_next;
            next_width_reg  <= next_width_next;
            run_state_reg   <= run_state_next;
            run_prev_reg    <= software_run_request_i;
            tick_cnt_reg    <= tick_cnt_next;
            delay_cnt_reg   <= delay_cnt_next;
            pos_reg         <= pos_next;
            act_period_reg  <= act_period_next;
            act_width_reg   <= act_width_next;
            pulse_reg       <= pulse_next;
            running_reg     <= running_next;
        end
    end

    // Gated by the request so an abort drops the pin in the same cycle
    assign pulse_output_o          = pulse_reg & software_run_request_i;
    assign sequence_running_flag_o = running_reg & software_run_request_i;
    assign active_period_us_o      = act_period_reg;

endmodule
`default_nettype wire

/* File: tb/pwmoc_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmoc_chk_sva
    import pwmoc_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        software_run_request_i,
    input wire logic        pulse_output_o,
    input wire logic        sequence_running_flag_o,
    input wire logic [31:0] active_period_us_o
);
    wire        run = software_run_request_i;
    wire        pls = pulse_output_o;
    wire        flg = sequence_running_flag_o;
    wire [31:0] act = active_period_us_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    AST_ABORT: assert property (!run |-> !pls && !flg)
        else $error("output active without run");
    AST_START: assert property ($rose(run) ##1 run |-> flg)
        else $error("no running flag after start");
    AST_IDLE: assert property (!flg |-> !pls)
        else $error("pulse outside sequence");
    AST_HOLD: assert property (flg ##1 run |-> flg)
        else $error("sequence dropped while run held");
    AST_RANGE: assert property (act >= PERIOD_MIN_HS_US && act <= TIME_MAX_US)
        else $error("period out of range");
    AST_PER_EDGE: assert property (flg && $past(flg) && $changed(act) |-> $rose(pls))
        else $error("period changed mid period");
    // Widths are whole microseconds, so no edge may follow within 8 cycles; an abort may
    AST_HIGH: assert property ($rose(pls) |-> (pls || !run)[*8])
        else $error("pulse shorter than tick");
    AST_LOW: assert property ($fell(pls) && run |-> !pls[*8])
        else $error("gap shorter than tick");
    cover property ($rose(flg));
    cover property ($rose(pls));
    cover property ($fell(flg));
endmodule
bind pwmoc_channel pwmoc_chk_sva u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .software_run_request_i(software_run_request_i), .pulse_output_o(pulse_output_o),
    .sequence_running_flag_o(sequence_running_flag_o),
    .active_period_us_o(active_period_us_o));
`default_nettype wire

/* File: tb/pwmoc_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Load on the pulse output: reports high time and rise-to-rise time at each fall
module pwmoc_load_model
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        pulse_i,
    output logic             rec_valid_o,
    output logic [31:0]      rec_width_o,
    output logic [31:0]      rec_period_o
);
    logic        prev_reg;
    logic [31:0] hi_reg, since_reg, per_reg;
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {prev_reg, rec_valid_o} <= 2'h0;
            {hi_reg, since_reg, per_reg, rec_width_o, rec_period_o} <= '0;
        end
        else
        begin
            prev_reg <= pulse_i;
            rec_valid_o <= pulse_i == 1'b0 && prev_reg == 1'b1;
            rec_width_o <= hi_reg;
            rec_period_o <= per_reg;
            since_reg <= (pulse_i && !prev_reg) ? 32'h1 : since_reg + 32'h1;
            hi_reg <= (pulse_i && !prev_reg) ? 32'h1 : hi_reg + {31'h0, pulse_i};
            if (pulse_i && !prev_reg)
                per_reg <= since_reg;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import pwmoc_pkg::*;
;
    logic        clock_i = 1'b0, rst_n_i = 1'b0, mon = 1'b1;
    logic        run = 1'b0, hs = 1'b1, cfg_ld = 1'b0, stb = 1'b0, pers = 1'b0;
    logic        iso = 1'b0, sync = 1'b0, cc = 1'b0;
    logic [31:0] app = 32'h0;
    logic signed [15:0] dith = 16'sh0;
    logic [1:0]  fmt = FMT_PCT, sel = SEL_PERIOD;
    logic [15:0] duty = 16'h0032, cdut = 16'h0000;
    logic [15:0] fs [4] = '{FS_ANALOG, FS_PCT, FS_PERMILLE, FS_PER10K};
    logic [31:0] per = 32'h14, dly = 32'h0, minw = 32'h0, ld_val = 32'h0;
    logic [31:0] seed, n, d, w, p, act, rw, rp;
    logic        pls, flg, rv;
    logic [31:0] exp_w [$], exp_p [$];
    int          error_cnt = 0, check_count = 0;
    always #10 clock_i = ~clock_i;
    pwmoc_channel dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .software_run_request_i(run),
        .duty_value_i(duty), .output_format_i(fmt), .high_speed_i(hs), .cfg_load_i(cfg_ld),
        .cfg_period_us_i(per), .cfg_on_delay_us_i(dly), .cfg_min_width_us_i(minw),
        .load_strobe_i(stb), .load_persistence_i(pers), .load_target_select_i(sel),
        .load_value_i(ld_val), .iso_mode_i(iso), .app_cycle_us_i(app), .cycle_sync_i(sync),
        .current_ctrl_i(cc), .current_duty_i(cdut), .dither_us_i(dith),
        .pulse_output_o(pls), .sequence_running_flag_o(flg), .active_period_us_o(act));
    pwmoc_load_model u_load (.clock_i(clock_i), .rst_n_i(rst_n_i), .pulse_i(pls),
        .rec_valid_o(rv), .rec_width_o(rw), .rec_period_o(rp));
    ////////////////////////////////////////
    task automatic check_val(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    // Period 0 marks the first pulse of a run, whose rise-to-rise time is undefined
    task automatic push(input logic [31:0] wu, input logic [31:0] pu);
        exp_w.push_back(wu * 50);
        exp_p.push_back(pu * 50);
    endtask
    task automatic drain(input int left);
        repeat (20000) if (exp_w.size() > left) @(posedge clock_i);
    endtask
    task automatic load(input logic [1:0] s, input logic [31:0] v, input logic keep);
        @(posedge clock_i);
        sel <= s;
        ld_val <= v;
        pers <= keep;
        stb <= ~keep;
        @(posedge clock_i);
        stb <= 1'b0;
    endtask
    task automatic delay_chk(input logic [31:0] du, input logic chg);
        @(posedge clock_i);
        run <= 1'b1;
        n = 0;
        if (chg)
            load(SEL_ON_DELAY, 32'h7, 1'b1);
        n = chg ? 2 : 0;
        while (pls !== 1'b1 && n < 5000)
        begin
            @(negedge clock_i);
            n++;
        end
        check_val({31'h0, n + 3 >= du * 50 && n <= du * 50 + 4}, 32'h1);
    endtask
    ////////////////////////////////////////
    always @(posedge clock_i)
        if (rv === 1'b1 && mon)
        begin
            w = exp_w.size() ? exp_w.pop_front() : 32'hFFFF_FFFF;
            p = exp_p.size() ? exp_p.pop_front() : 32'h0;
            check_val(rw, w);
            if (p != 0)
                check_val(rp, p);
        end
    initial
    begin
        tick(90000);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        seed = $urandom(32'h96CC);
        tick(10);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        cfg_ld <= 1'b1;
        @(posedge clock_i);
        cfg_ld <= 1'b0;
        for (int f = 0; f < 4; f++)
        begin
            // Duty kept inside 10..90 percent so the abort always lands in a gap
            d = fs[f] / 10 + $urandom % (fs[f] * 8 / 10);
            fmt <= f[1:0];
            duty <= d[15:0];
            tick(300);
            for (int i = 0; i < 3; i++)
                push(20 * d / fs[f], i ? 20 : 0);
            run <= 1'b1;
            drain(0);
            run <= 1'b0;
        end
        fmt <= FMT_PCT;
        duty <= 16'h0032;
        tick(300);
        push(10, 0);
        push(10, 20);
        push(2, 20);
        push(2, 10);
        run <= 1'b1;
        drain(3);
        @(posedge pls);
        load(SEL_PERIOD, 32'h3, 1'b0);
        duty <= 16'h0019;
        drain(0);
        run <= 1'b0;
        check_val(act, 32'hA);
        mon <= 1'b0;
        hs <= 1'b0;
        load(SEL_PERIOD, 32'h32, 1'b1);
        run <= 1'b1;
        tick(12000);
        check_val(act, 32'h64);
        run <= 1'b0;
        load(SEL_ON_DELAY, 32'h4, 1'b0);
        tick(300);
        delay_chk(4, 1'b1);
        tick(1500);
        run <= 1'b0;
        tick(300);
        delay_chk(7, 1'b0);
        tick(1500);
        run <= 1'b0;
        // Isochronous: 50 us against a 30 us cycle rounds to 2:1, the 7 us delay is ignored
        iso <= 1'b1;
        hs <= 1'b1;
        app <= 32'h1E;
        tick(300);
        run <= 1'b1;
        tick(40);
        check_val({31'h0, pls}, 32'h0);
        sync <= 1'b1;
        @(posedge clock_i);
        sync <= 1'b0;
        @(negedge clock_i);
        check_val({31'h0, pls}, 32'h1);
        check_val(act, 32'h3C);
        tick(100);
        run <= 1'b0;
        // Minimum 5 us: a 20 us dither would overrun the period and is cut to 15 us
        iso <= 1'b0;
        pers <= 1'b0;
        minw <= 32'h5;
        dith <= 16'sh0014;
        cfg_ld <= 1'b1;
        @(posedge clock_i);
        cfg_ld <= 1'b0;
        tick(300);
        mon <= 1'b1;
        push(15, 0);
        push(15, 20);
        run <= 1'b1;
        drain(0);
        run <= 1'b0;
        // Current control ignores both the minimum width and the dither
        cc <= 1'b1;
        d = 32'h3E8 + $urandom % 32'h1F40;
        cdut <= d[15:0];
        tick(300);
        push(20 * d / FS_PER10K, 0);
        push(20 * d / FS_PER10K, 20);
        run <= 1'b1;
        drain(0);
        run <= 1'b0;
        // 16 us passes period minus minimum, so two whole periods stay high
        cc <= 1'b0;
        duty <= 16'h0050;
        tick(300);
        push(40, 0);
        run <= 1'b1;
        tick(1820);
        check_val({31'h0, pls}, 32'h1);
        duty <= 16'h0014;
        tick(1000);
        check_val({31'h0, pls}, 32'h0);
        drain(0);
        run <= 1'b0;
        tick(5);
        complete_run();
    end
endmodule
`default_nettype wire
